// [hw/cam_consts.vh]
`ifndef CAM_CONSTS_VH
`define CAM_CONSTS_VH
// Register byte offsets
`define CAM_OFS_MASK_STD0 12'h000
`define CAM_OFS_MASK_EXT0 12'h004
`define CAM_OFS_MASK_STD1 12'h008
`define CAM_OFS_MASK_EXT1 12'h00C
`define CAM_OFS_MASK_STD2 12'h010
`define CAM_OFS_MASK_EXT2 12'h014
`define CAM_OFS_FULL_LO 12'h020
`define CAM_OFS_FULL_HI 12'h024
`define CAM_OFS_OVF_LO 12'h028
`define CAM_OFS_OVF_HI 12'h02C
`define CAM_OFS_CTRL01 12'h030
`define CAM_OFS_CTRL23 12'h034
`define CAM_OFS_CTRL45 12'h038
`define CAM_OFS_CTRL67 12'h03C
`define CAM_OFS_FSEL 12'h040
`define CAM_OFS_FLT_STD 12'h044
`define CAM_OFS_FLT_EXT 12'h048
`define CAM_OFS_MATCH 12'h04C
// Mask standard register fields
`define CAM_STD_LSB 5
`define CAM_MODE_BIT 3
// Buffer control fields, per byte
`define CAM_DIR_BIT 7
`define CAM_ABT_BIT 6
`define CAM_LARB_BIT 5
`define CAM_ERR_BIT 4
`define CAM_REQ_BIT 3
`define CAM_RTR_BIT 2
`define CAM_PRI_LSB 0
// Reset values
`define CAM_FLAGS_RST 32'h0000_0000
`define CAM_CTRL_RST 8'h00
`define CAM_FSEL_RST 2'h0
// Mask source encodings
`define CAM_SRC_NONE 2'h3
`endif

// [hw/cam_accept_ctrl.v]
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`include "cam_consts.vh"
module cam_accept_ctrl (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire msg_valid,
   input wire [10:0] msg_std_ident,
   input wire [17:0] msg_ext_ident,
   input wire msg_is_ext,
   output wire msg_accept,
   input wire rx_store,
   input wire [4:0] rx_store_slot,
   input wire [7:0] tx_done,
   input wire [7:0] tx_abort_done,
   input wire [7:0] tx_lost_arb,
   input wire [7:0] tx_bus_err,
   input wire [7:0] remote_rx,
   output wire [7:0] abort_req,
   output wire [7:0] buffer_direction,
   output wire tx_pending,
   output wire [2:0] tx_next_slot,
   output wire ram_req,
   output wire ram_we,
   output wire [4:0] ram_slot,
   input wire ram_ack
);
   reg [15:0] mask_std_id_reg [0:2];
   reg [15:0] mask_ext_id_reg [0:2];
   reg [31:0] rx_full_reg;
   reg [31:0] rx_ovf_reg;
   reg [7:0] ctrl_reg [0:7];
   reg [1:0] fsel_reg;
   reg [15:0] flt_std_reg;
   reg [15:0] flt_ext_reg;
   reg match_reg;
   reg aph_wr_reg;
   reg [11:0] aph_addr_reg;
   reg [7:0] abort_reg;
   integer i;
   genvar g;
   wire [7:0] req_vec;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire take = hsel & hready & htrans[1];
   wire wr = aph_wr_reg;
   wire [11:0] wa = aph_addr_reg;

   // Ctrl byte for buffer b lives in word 12 + b/2, byte lane b%2
   function [7:0] ctrl_of;
      input [15:0] w;
      input odd;
      begin
         ctrl_of = odd ? w[15:8] : w[7:0];
      end
   endfunction

   function is_ofs;
      input [11:0] a;
      input [11:0] o;
      begin
         is_ofs = (a == o);
      end
   endfunction

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_wr_reg <= 1'b0;
         aph_addr_reg <= 12'h000;
      end else begin
         aph_wr_reg <= take & hwrite;
         aph_addr_reg <= haddr[11:0];
      end
   end

   // mask sets have no reset, they hold unknown until written
   generate
      for (g = 0; g < 3; g = g + 1) begin : mask_set
         localparam integer STD_OFS = `CAM_OFS_MASK_STD0 + g * 8;
         localparam integer EXT_OFS = `CAM_OFS_MASK_EXT0 + g * 8;
         always @(posedge hclk) begin
            if (wr && is_ofs(wa, STD_OFS[11:0]))
               mask_std_id_reg[g] <= hwdata[15:0] & 16'hFFEB;
            if (wr && is_ofs(wa, EXT_OFS[11:0]))
               mask_ext_id_reg[g] <= hwdata[15:0];
         end
      end
   endgenerate

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fsel_reg <= `CAM_FSEL_RST;
         flt_std_reg <= 16'h0000;
         flt_ext_reg <= 16'h0000;
      end else begin
         if (wr && is_ofs(wa, `CAM_OFS_FSEL))
            fsel_reg <= hwdata[1:0];
         if (wr && is_ofs(wa, `CAM_OFS_FLT_STD))
            flt_std_reg <= hwdata[15:0] & 16'hFFEB;
         if (wr && is_ofs(wa, `CAM_OFS_FLT_EXT))
            flt_ext_reg <= hwdata[15:0];
      end
   end

   wire no_mask = (fsel_reg == `CAM_SRC_NONE);
   wire [1:0] ms = no_mask ? 2'h0 : fsel_reg;
   wire [15:0] sel_std = no_mask ? 16'hFFFF : mask_std_id_reg[ms];
   wire [15:0] sel_ext = no_mask ? 16'hFFFF : mask_ext_id_reg[ms];
   wire [10:0] std_en = sel_std[15:`CAM_STD_LSB];
   wire [17:0] ext_en = {sel_std[1:0], sel_ext};
   wire [17:0] flt_ext = {flt_std_reg[1:0], flt_ext_reg};
   wire std_ok = ((msg_std_ident ^ flt_std_reg[15:5]) & std_en) == 11'h000;
   wire ext_ok = ((msg_ext_ident ^ flt_ext) & ext_en) == 18'h00000;
   wire type_mode = no_mask ? 1'b1 : sel_std[`CAM_MODE_BIT];
   // bit 3 of the filter standard register picks the accepted type
   wire type_ok = (msg_is_ext == flt_std_reg[3]);
   assign msg_accept = msg_valid & std_ok & (~msg_is_ext | ext_ok) &
      (~type_mode | type_ok);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         match_reg <= 1'b0;
      else if (msg_valid)
         match_reg <= msg_accept;
   end

   // Receive flags
   wire [31:0] store_hit = rx_store ? (32'h0000_0001 << rx_store_slot) : 32'h0000_0000;
   reg [31:0] full_clr;
   reg [31:0] ovf_clr;
   always @* begin
      full_clr = 32'h0000_0000;
      ovf_clr = 32'h0000_0000;
      // writing 0 clears, writing 1 is ignored
      if (wr && is_ofs(wa, `CAM_OFS_FULL_LO))
         full_clr[15:0] = ~hwdata[15:0];
      if (wr && is_ofs(wa, `CAM_OFS_FULL_HI))
         full_clr[31:16] = ~hwdata[15:0];
      if (wr && is_ofs(wa, `CAM_OFS_OVF_LO))
         ovf_clr[15:0] = ~hwdata[15:0];
      if (wr && is_ofs(wa, `CAM_OFS_OVF_HI))
         ovf_clr[31:16] = ~hwdata[15:0];
   end

   // Set wins over a clear in the same cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_full_reg <= `CAM_FLAGS_RST;
         rx_ovf_reg <= `CAM_FLAGS_RST;
      end else begin
         rx_full_reg <= (rx_full_reg & ~full_clr) | store_hit;
         // overflow on store into a full buffer
         rx_ovf_reg <= (rx_ovf_reg & ~ovf_clr) | (store_hit & rx_full_reg);
      end
   end

   // Per-buffer control bytes
   generate
      for (g = 0; g < 8; g = g + 1) begin : buf_ctl
         // even buffer low byte, odd buffer high byte
         localparam integer CTRL_OFS = `CAM_OFS_CTRL01 + (g / 2) * 4;
         localparam integer LANE = g % 2;
         wire hit = wr && is_ofs(wa, CTRL_OFS[11:0]);
         wire [7:0] wb = ctrl_of(hwdata[15:0], LANE[0]);
         wire [7:0] cur = ctrl_reg[g];
         wire sw_req = hit & wb[`CAM_REQ_BIT];
         // clearing a set request asks for abort
         wire sw_abort = hit & ~wb[`CAM_REQ_BIT] & cur[`CAM_REQ_BIT];
         wire rtr_set = remote_rx[g] & cur[`CAM_RTR_BIT];
         wire req_set = (sw_req | rtr_set) & ~cur[`CAM_REQ_BIT];
         reg [7:0] nx;
         always @* begin
            nx = cur;
            if (hit) begin
               nx[`CAM_DIR_BIT] = wb[`CAM_DIR_BIT];
               nx[`CAM_RTR_BIT] = wb[`CAM_RTR_BIT];
               nx[`CAM_PRI_LSB + 1:`CAM_PRI_LSB] = wb[`CAM_PRI_LSB + 1:`CAM_PRI_LSB];
               nx[`CAM_REQ_BIT] = wb[`CAM_REQ_BIT];
            end
            if (tx_done[g] | tx_abort_done[g])
               nx[`CAM_REQ_BIT] = 1'b0;
            if (rtr_set)
               nx[`CAM_REQ_BIT] = 1'b1;
            if (tx_abort_done[g])
               nx[`CAM_ABT_BIT] = 1'b1;
            if (tx_lost_arb[g])
               nx[`CAM_LARB_BIT] = 1'b1;
            if (tx_bus_err[g])
               nx[`CAM_ERR_BIT] = 1'b1;
            if (req_set) begin
               nx[`CAM_ABT_BIT] = 1'b0;
               nx[`CAM_LARB_BIT] = 1'b0;
               nx[`CAM_ERR_BIT] = 1'b0;
            end
         end
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ctrl_reg[g] <= `CAM_CTRL_RST;
               abort_reg[g] <= 1'b0;
            end else begin
               ctrl_reg[g] <= nx;
               // abort held until engine reports completion or a new request is set
               if (sw_abort)
                  abort_reg[g] <= 1'b1;
               else if (tx_abort_done[g] | tx_done[g] | req_set)
                  abort_reg[g] <= 1'b0;
            end
         end
         assign buffer_direction[g] = cur[`CAM_DIR_BIT];
         assign req_vec[g] = cur[`CAM_REQ_BIT];
      end
   endgenerate
   assign abort_req = abort_reg;

   // highest priority pending transmit buffer, lowest index on tie
   reg [2:0] best;
   reg [2:0] best_pri;
   reg any;
   always @* begin
      best = 3'h0;
      best_pri = 3'h0;
      any = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         if (ctrl_reg[i][`CAM_DIR_BIT] && ctrl_reg[i][`CAM_REQ_BIT] && !abort_reg[i] &&
            (!any || {1'b0, ctrl_reg[i][1:0]} > best_pri)) begin
            best = i[2:0];
            best_pri = {1'b0, ctrl_reg[i][1:0]};
            any = 1'b1;
         end
      end
   end
   assign tx_pending = any;
   assign tx_next_slot = best;

   // message contents go through the DMA RAM port
   reg ram_busy_reg;
   reg ram_we_reg;
   reg [4:0] ram_slot_reg;
   reg store_wait_reg;
   reg [4:0] store_wait_slot_reg;
   reg [7:0] fetched_reg;

   // A store that meets a busy port waits here so its RAM write is not lost;
   // only one can wait, a further store in that window replaces it
   wire store_now = ~ram_busy_reg & ~store_wait_reg & rx_store;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         store_wait_reg <= 1'b0;
         store_wait_slot_reg <= 5'h00;
      end else if (rx_store && !store_now) begin
         store_wait_reg <= 1'b1;
         store_wait_slot_reg <= rx_store_slot;
      end else if (!ram_busy_reg) begin
         store_wait_reg <= 1'b0;
      end
   end

   // Fetch the next buffer once per request; refetching would hog the port
   wire fetch_now = any & ~fetched_reg[best];
   wire [7:0] fetch_hit = (fetch_now & ~ram_busy_reg & ~store_wait_reg & ~rx_store) ?
      (8'h01 << best) : 8'h00;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         fetched_reg <= 8'h00;
      else
         fetched_reg <= (fetched_reg | fetch_hit) & req_vec;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ram_busy_reg <= 1'b0;
         ram_we_reg <= 1'b0;
         ram_slot_reg <= 5'h00;
      end else if (ram_busy_reg) begin
         if (ram_ack)
            ram_busy_reg <= 1'b0;
      end else if (store_wait_reg) begin
         ram_busy_reg <= 1'b1;
         ram_we_reg <= 1'b1;
         ram_slot_reg <= store_wait_slot_reg;
      end else if (rx_store) begin
         ram_busy_reg <= 1'b1;
         ram_we_reg <= 1'b1;
         ram_slot_reg <= rx_store_slot;
      end else if (fetch_now) begin
         ram_busy_reg <= 1'b1;
         ram_we_reg <= 1'b0;
         ram_slot_reg <= {2'h0, best};
      end
   end
   assign ram_req = ram_busy_reg;
   assign ram_we = ram_we_reg;
   assign ram_slot = ram_slot_reg;

   // Read mux, registered on the address phase
   reg [31:0] rd;
   always @* begin
      rd = 32'h0000_0000;
      case (haddr[11:0])
         `CAM_OFS_MASK_STD0: rd[15:0] = mask_std_id_reg[0];
         `CAM_OFS_MASK_EXT0: rd[15:0] = mask_ext_id_reg[0];
         `CAM_OFS_MASK_STD1: rd[15:0] = mask_std_id_reg[1];
         `CAM_OFS_MASK_EXT1: rd[15:0] = mask_ext_id_reg[1];
         `CAM_OFS_MASK_STD2: rd[15:0] = mask_std_id_reg[2];
         `CAM_OFS_MASK_EXT2: rd[15:0] = mask_ext_id_reg[2];
         `CAM_OFS_FULL_LO: rd[15:0] = rx_full_reg[15:0];
         `CAM_OFS_FULL_HI: rd[15:0] = rx_full_reg[31:16];
         `CAM_OFS_OVF_LO: rd[15:0] = rx_ovf_reg[15:0];
         `CAM_OFS_OVF_HI: rd[15:0] = rx_ovf_reg[31:16];
         `CAM_OFS_CTRL01: rd[15:0] = {ctrl_reg[1], ctrl_reg[0]};
         `CAM_OFS_CTRL23: rd[15:0] = {ctrl_reg[3], ctrl_reg[2]};
         `CAM_OFS_CTRL45: rd[15:0] = {ctrl_reg[5], ctrl_reg[4]};
         `CAM_OFS_CTRL67: rd[15:0] = {ctrl_reg[7], ctrl_reg[6]};
         `CAM_OFS_FSEL: rd[1:0] = fsel_reg;
         `CAM_OFS_FLT_STD: rd[15:0] = flt_std_reg;
         `CAM_OFS_FLT_EXT: rd[15:0] = flt_ext_reg;
         `CAM_OFS_MATCH: rd[0] = match_reg;
         default: rd = 32'h0000_0000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= rd;
   end
endmodule // cam_accept_ctrl

// [tb/cam_accept_ctrl_assertions.sv]
`timescale 1ns/10ps
module cam_accept_ctrl_chk (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire [7:0] tx_done,
   input wire [7:0] tx_abort_done,
   input wire [7:0] abort_req,
   input wire [7:0] buffer_direction,
   input wire tx_pending,
   input wire [2:0] tx_next_slot,
   input wire ram_req,
   input wire ram_we,
   input wire [4:0] ram_slot,
   input wire ram_ack
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   AST_RESET_CLEAR: assert property ($rose(hresetn) |-> !ram_req && buffer_direction == 8'h00)
      else $error("outputs not cleared by reset");
   AST_PEND_IS_TX: assert property (tx_pending |-> buffer_direction[tx_next_slot])
      else $error("receive buffer offered for sending");
   AST_PEND_NO_ABORT: assert property (tx_pending |-> !abort_req[tx_next_slot])
      else $error("aborting buffer offered for sending");
   AST_ABORT_ENDS: assert property (tx_abort_done[0] |=> !abort_req[0])
      else $error("abort request outlives abort");
   AST_DONE_CLEARS: assert property (tx_done[1] |=> !(tx_pending && tx_next_slot == 3'h1))
      else $error("sent buffer still pending");
   AST_RAM_HOLD: assert property (ram_req && !ram_ack |=> ram_req && $stable(ram_slot))
      else $error("ram request dropped or moved");
   AST_RAM_RELEASE: assert property ($fell(ram_req) |-> $past(ram_ack))
      else $error("ram request ended without ack");
endmodule // cam_accept_ctrl_chk
bind cam_accept_ctrl cam_accept_ctrl_chk i_chk (.hclk, .hresetn, .hreadyout, .hresp, .tx_done,
   .tx_abort_done, .abort_req, .buffer_direction, .tx_pending, .tx_next_slot, .ram_req, .ram_we,
   .ram_slot, .ram_ack);

// [tb/cam_ram_model.sv]
`timescale 1ns/10ps
module cam_ram_model #(parameter int DELAY = 2) (
   input wire hclk,
   input wire hresetn,
   input wire ram_req,
   output logic ram_ack
);
   int cnt;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         ram_ack <= 1'b0;
      end else if (ram_req && !ram_ack && cnt == DELAY) begin
         cnt <= 0;
         ram_ack <= 1'b1;
      end else begin
         cnt <= (ram_req && !ram_ack) ? cnt + 1 : 0;
         ram_ack <= 1'b0;
      end
   end
endmodule // cam_ram_model

// [tb/tb_can_accept_mask_and_buffer_status.sv]
`timescale 1ns/10ps
module tb_can_accept_mask_and_buffer_status;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e;} cam_row_t;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, msg_is_ext = 0, rx_store = 0;
   logic msg_valid = 1;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0;
   logic [10:0] msg_std_ident = 0;
   logic [17:0] msg_ext_ident = 0;
   logic [4:0] rx_store_slot = 0, ram_slot;
   logic [7:0] tx_done = 0, tx_abort_done = 0, tx_lost_arb = 0, tx_bus_err = 0, remote_rx = 0;
   logic [7:0] abort_req, buffer_direction;
   logic [2:0] tx_next_slot;
   logic hreadyout, hresp, msg_accept, tx_pending, ram_req, ram_we, ram_ack;
   int failures = 0, total_checks = 0;
   cam_row_t rows[13] = '{'{0, 12'h020, 0, 0}, '{0, 12'h024, 0, 0}, '{0, 12'h028, 0, 0},
      '{0, 12'h02C, 0, 0}, '{0, 12'h030, 0, 0}, '{0, 12'h034, 0, 0}, '{0, 12'h038, 0, 0},
      '{0, 12'h03C, 0, 0}, '{1, 12'h000, 32'hFFFF, 32'hFFEB}, '{1, 12'h008, 32'h1234, 32'h1220},
      '{1, 12'h014, 32'h5A5A, 32'h5A5A}, '{1, 12'h030, 32'h0070, 0}, '{1, 12'h050, 32'h1234, 0}};
   // Row: mask source, std mask, std id, ext id, is ext, accept
   logic [48:0] ft[10] = '{{2'h0, 16'hFFE0, 11'h123, 18'h0, 2'b01},
      {2'h0, 16'hFFE0, 11'h122, 18'h0, 2'b00}, {2'h0, 16'hFFC0, 11'h122, 18'h0, 2'b01},
      {2'h0, 16'hFFE3, 11'h123, 18'h1, 2'b10}, {2'h0, 16'hFFE3, 11'h123, 18'h0, 2'b11},
      {2'h0, 16'hFFEB, 11'h123, 18'h0, 2'b10}, {2'h0, 16'hFFEB, 11'h123, 18'h0, 2'b01},
      {2'h2, 16'hFFEB, 11'h7FF, 18'h0, 2'b01}, {2'h3, 16'hFFEB, 11'h7FF, 18'h0, 2'b00},
      {2'h3, 16'hFFEB, 11'h123, 18'h0, 2'b01}};
   cam_accept_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .msg_valid,
      .msg_std_ident, .msg_ext_ident, .msg_is_ext, .msg_accept, .rx_store, .rx_store_slot,
      .tx_done, .tx_abort_done, .tx_lost_arb, .tx_bus_err, .remote_rx, .abort_req,
      .buffer_direction, .tx_pending, .tx_next_slot, .ram_req, .ram_we, .ram_slot, .ram_ack);
   cam_ram_model #(.DELAY(3)) i_ram (.hclk, .hresetn, .ram_req, .ram_ack);
   initial forever #5 hclk = ~hclk;
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h00000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 0);
      chk(n, e, q);
   endtask
   // Order: done, abort done, lost arbitration, bus error, remote frame
   task automatic ev(input logic [39:0] v);
      @(posedge hclk);
      {tx_done, tx_abort_done, tx_lost_arb, tx_bus_err, remote_rx} <= v;
      @(posedge hclk);
      {tx_done, tx_abort_done, tx_lost_arb, tx_bus_err, remote_rx} <= 40'h0;
   endtask
   task automatic store(input logic [4:0] s);
      @(posedge hclk);
      rx_store <= 1'b1;
      rx_store_slot <= s;
      @(posedge hclk);
      rx_store <= 1'b0;
      #1;
      chk("ram store", {25'h0, 2'b11, s}, {25'h0, ram_req, ram_we, ram_slot});
      for (int n = 0; n < 30 && (n < 2 || ram_req !== 1'b0); n++) @(posedge hclk);
   endtask
   task automatic pend(input logic [3:0] e);
      @(posedge hclk);
      #1;
      chk("pending slot", {28'h0, e}, {28'h0, tx_pending, tx_next_slot});
   endtask
   task report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
         rd($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
      end
      $display("register table done");
      store(5'd3);
      store(5'd3);
      store(5'd20);
      rd("full lo", 12'h020, 32'h8);
      rd("ovf lo", 12'h028, 32'h8);
      rd("full hi", 12'h024, 32'h10);
      bus(1'b1, 12'h020, 32'hFFF7);
      rd("full lo cleared", 12'h020, 32'h0);
      bus(1'b1, 12'h024, 32'hFFFF);
      rd("full hi kept", 12'h024, 32'h10);
      $display("flag test done");
      bus(1'b1, 12'h030, 32'h8B89);
      pend(4'h9);
      ev(40'h0000020200);
      rd("ctrl status", 12'h030, 32'hBB89);
      ev(40'h0200000000);
      rd("ctrl sent", 12'h030, 32'hB389);
      pend(4'h8);
      bus(1'b1, 12'h030, 32'h8381);
      @(posedge hclk);
      #1;
      chk("abort", 32'h1, {23'h0, tx_pending, abort_req});
      ev(40'h0001000000);
      rd("ctrl aborted", 12'h030, 32'hB3C1);
      bus(1'b1, 12'h030, 32'h8BC1);
      rd("ctrl resend", 12'h030, 32'h8BC1);
      bus(1'b1, 12'h034, 32'h8086);
      ev(40'h000000000C);
      rd("ctrl remote", 12'h034, 32'h808E);
      chk("direction", 32'h0F, {24'h0, buffer_direction});
      pend(4'h9);
      $display("buffer control test done");
      bus(1'b1, 12'h044, 32'h2460);
      bus(1'b1, 12'h048, 32'h0);
      bus(1'b1, 12'h004, 32'hFFFF);
      bus(1'b1, 12'h010, 32'h0);
      foreach (ft[i]) begin
         bus(1'b1, 12'h040, {30'h0, ft[i][48:47]});
         bus(1'b1, 12'h000, {16'h0, ft[i][46:31]});
         {msg_std_ident, msg_ext_ident, msg_is_ext} <= ft[i][30:1];
         @(posedge hclk);
         #1;
         chk($sformatf("accept %0d", i), {31'h0, ft[i][0]}, {31'h0, msg_accept});
      end
      rd("last match", 12'h04C, 32'h1);
      msg_valid <= 1'b0;
      @(posedge hclk);
      #1;
      chk("accept idle", 32'h0, {31'h0, msg_accept});
      rd("match held", 12'h04C, 32'h1);
      $display("filter test done");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk("reset outputs", 32'h0, {15'h0, tx_pending, abort_req, buffer_direction});
      rd("full hi reset", 12'h024, 32'h0);
      rd("ovf lo reset", 12'h028, 32'h0);
      rd("ctrl reset", 12'h030, 32'h0);
      $display("reset test done");
      report_and_stop;
   end
   initial begin
      #200000;
      failures++;
      report_and_stop;
   end
endmodule // tb_can_accept_mask_and_buffer_status
